// ---- hdl/serial_slave_pkg.sv ----
// Constants and carrier types of the addressed serial slave
package serial_slave_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned LINE_BAUD = 9600;
   localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / LINE_BAUD;
   localparam int unsigned TIMER_W = 12;
   localparam int unsigned CODE_BITS = 7;
   localparam int unsigned FRAME_BITS = 8;
   localparam int unsigned RX_FIFO_DEPTH = 8;
   localparam int unsigned VALUE_W = 16;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [6:0] CH_STX = 7'h02;
   localparam logic [6:0] CH_ETX = 7'h03;
   localparam logic [6:0] CH_EOT = 7'h04;
   localparam logic [6:0] CH_ENQ = 7'h05;
   localparam logic [6:0] CH_ACK = 7'h06;
   localparam logic [6:0] CH_NAK = 7'h15;
   localparam logic [6:0] CH_DIGIT_0 = 7'h30;
   localparam logic [6:0] CH_DIGIT_9 = 7'h39;
   localparam logic [6:0] CH_EQUALS = 7'h3d;
   localparam logic [1:0] ADDR_TAG = 2'h2;
   localparam logic [4:0] NODE_ANY = 5'h00;
   localparam logic [4:0] NODE_MIN = 5'h01;
   localparam logic [4:0] NODE_MAX = 5'h1e;
   localparam logic [4:0] NODE_BCAST = 5'h1f;
   localparam logic [VALUE_W-1:0] VALUE_MAX = 16'hffff;
   localparam logic [VALUE_W-1:0] SPEED_FULL = 16'h1fff;
   localparam logic [VALUE_W-1:0] DECIMAL_BASE = 16'h000a;

   typedef struct packed {
      logic is_digit;
      logic is_ctrl;
      logic [CODE_BITS-1:0] code;
   } rx_char_t;

   typedef struct packed {
      logic last;
      logic [CODE_BITS-1:0] code;
   } tx_char_t;
endpackage : serial_slave_pkg

// ---- hdl/bit_timer.sv ----
// Loadable down-counter that paces serial bit periods
`timescale 1ns/1ps
`default_nettype none
module bit_timer #(
   parameter int unsigned W = 12
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic en, // Clock enable
   input wire logic load, // Restart count
   input wire logic [W-1:0] load_val, // Cycles minus one
   output logic zero // Count has expired
);
   logic [W-1:0] count_reg;

   generate
      if (W < 2) begin : g_bad_width
         $error("bit_timer width too small");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= '0;
      end else if (en) begin
         if (load) begin
            count_reg <= load_val;
         end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   assign zero = (count_reg == '0);
endmodule : bit_timer
`default_nettype wire

// ---- hdl/char_fifo.sv ----
// Synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic en, // Clock enable
   input wire logic in_valid, // Write request
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Data available
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Read data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_idx_reg;
   logic [AW-1:0] rd_idx_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
         $error("char_fifo depth below two");
      end
   endgenerate

   assign in_ready = (count_reg != FULL_COUNT);
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_idx_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (en && push) begin
         mem_reg[wr_idx_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         count_reg <= '0;
      end else if (en) begin
         if (push) begin
            wr_idx_reg <= (wr_idx_reg == LAST_IDX) ? '0 : wr_idx_reg + 1'b1;
         end
         if (pop) begin
            rd_idx_reg <= (rd_idx_reg == LAST_IDX) ? '0 : rd_idx_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : char_fifo
`default_nettype wire

// ---- hdl/addressed_ascii_serial_slave.sv ----
// Addressed ASCII serial slave: framing, addressing and answer gating
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Both directions run at 9600 bit/s.
// - Transmit only inside an answer window opened by a request.
// - Requests to our own node address 1 to 30 are accepted.
// - Address 0 is accepted whatever our node address is.
// - Address 31 is broadcast and never opens an answer.
// - Address characters are 40h plus node number, 0 to 31.
// - Digits are 30h to 39h, equals sign 3Dh.
// - Controls STX 02h ETX 03h EOT 04h ENQ 05h ACK 06h NAK 15h.
// - Half duplex: no transmit while receiving.
// - Frame is start, seven code bits, even parity bit, stop.
// - Data bits go least significant first right after start.
// - Numeric values are decimal integers with no decimal point.
// - Speed values are 13 bit, full scale 8191.
// - Accepted request characters go out for command decoding.
// - Block check mismatch raises a sticky alarm, nothing else.
module addressed_ascii_serial_slave
   import serial_slave_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH,
   parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
   input wire logic CLK, // System clock
   input wire logic RST, // Synchronous reset
   input wire logic CE, // Clock enable
   input wire logic [4:0] NODE_ADDRESS, // Node address setting
   input wire logic RXD, // Serial receive line
   output logic TXD, // Serial transmit line
   output logic TX_OE, // Line driver enable
   output rx_char_t RX_CHAR, // Accepted request character
   output logic RX_VALID, // RX_CHAR holds data
   input wire logic RX_READY, // RX_CHAR consumed
   input wire tx_char_t TX_CHAR, // Answer character
   input wire logic TX_VALID, // TX_CHAR offered
   output logic TX_READY, // TX_CHAR will be taken
   output logic RX_ERROR, // Framing or parity fault
   output logic RX_OVERRUN, // Character lost, buffer full
   output logic BLOCK_CHECK_ALARM, // Block check error alarm
   input wire logic ALARM_CLEAR, // Clears the alarm
   output logic REQ_BROADCAST, // Current request is broadcast
   output logic ANSWER_WINDOW, // Answer is permitted
   output logic [VALUE_W-1:0] VALUE, // Last decimal value
   output logic VALUE_STROBE, // VALUE updated
   output logic VALUE_IN_SCALE // VALUE within speed full scale
);
   localparam logic [TIMER_W-1:0] BIT_LOAD = TIMER_W'(BIT_CYCLES - 1);
   localparam logic [TIMER_W-1:0] HALF_LOAD = TIMER_W'(BIT_CYCLES / 2 - 1);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {
      LINK_ADDR, LINK_SKIP, LINK_BODY, LINK_BCC, LINK_ANSWER
   } link_state_t;

   generate
      if (BIT_CYCLES < 4 || BIT_CYCLES >= (1 << TIMER_W)) begin : g_bad_rate
         $error("BIT_CYCLES out of timer range");
      end
      if (FIFO_DEPTH < 2) begin : g_bad_depth
         $error("FIFO_DEPTH below two");
      end
   endgenerate

   rx_state_t rx_state_reg;
   tx_state_t tx_state_reg;
   link_state_t link_state_reg;
   logic rxd_prev_reg;
   logic [FRAME_BITS-1:0] rx_shift_reg;
   logic [2:0] rx_cnt_reg;
   logic rx_done_reg;
   logic rx_good_reg;
   logic [FRAME_BITS-1:0] tx_shift_reg;
   logic [2:0] tx_cnt_reg;
   logic tx_last_reg;
   logic tx_sent_reg;
   logic txd_reg;
   logic tx_oe_reg;
   logic tx_ready_reg;
   logic [CODE_BITS-1:0] bcc_reg;
   logic alarm_reg;
   logic bcast_reg;
   logic push_reg;
   rx_char_t push_char_reg;
   logic rx_error_reg;
   logic overrun_reg;
   logic armed_reg;
   logic [VALUE_W-1:0] acc_reg;
   logic [VALUE_W-1:0] value_reg;
   logic value_strobe_reg;
   logic value_scale_reg;
   rx_char_t out_char_reg;
   logic out_valid_reg;
   logic rx_load;
   logic rx_zero;
   logic [TIMER_W-1:0] rx_load_val;
   logic tx_load;
   logic tx_zero;
   logic tx_take;
   logic [CODE_BITS-1:0] rx_code;
   logic rx_is_addr;
   logic [4:0] rx_node;
   logic own_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   rx_char_t fifo_out_data;
   logic [VALUE_W-1:0] digit_val;
   logic [VALUE_W+3:0] acc_wide;

   // Receive bit timing
   always_comb begin
      rx_load = 1'b0;
      rx_load_val = BIT_LOAD;
      unique case (rx_state_reg)
         RX_IDLE: begin
            rx_load = rxd_prev_reg && !RXD;
            rx_load_val = HALF_LOAD;
         end
         RX_START, RX_DATA: begin
            rx_load = rx_zero;
         end
         RX_STOP: begin
            rx_load = 1'b0;
         end
      endcase
   end

   bit_timer #(.W(TIMER_W)) u_rx_timer (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .load(rx_load),
      .load_val(rx_load_val),
      .zero(rx_zero)
   );

   assign tx_take = TX_VALID && tx_ready_reg;
   assign tx_load = tx_take || (tx_state_reg != TX_IDLE && tx_zero);

   bit_timer #(.W(TIMER_W)) u_tx_timer (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .load(tx_load),
      .load_val(BIT_LOAD),
      .zero(tx_zero)
   );

   // Receiver: start, eight data bits, stop
   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_state_reg <= RX_IDLE;
         rxd_prev_reg <= 1'b1;
         rx_shift_reg <= '0;
         rx_cnt_reg <= '0;
         rx_done_reg <= 1'b0;
         rx_good_reg <= 1'b0;
      end else if (CE) begin
         rxd_prev_reg <= RXD;
         rx_done_reg <= 1'b0;
         unique case (rx_state_reg)
            RX_IDLE: begin
               if (rxd_prev_reg && !RXD) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               if (rx_zero) begin
                  rx_state_reg <= RXD ? RX_IDLE : RX_DATA;
                  rx_cnt_reg <= '0;
               end
            end
            RX_DATA: begin
               if (rx_zero) begin
                  rx_shift_reg <= {RXD, rx_shift_reg[FRAME_BITS-1:1]};
                  rx_cnt_reg <= rx_cnt_reg + 1'b1;
                  if (rx_cnt_reg == LAST_BIT) begin
                     rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_zero) begin
                  rx_state_reg <= RX_IDLE;
                  rx_done_reg <= 1'b1;
                  rx_good_reg <= RXD && !(^rx_shift_reg);
               end
            end
         endcase
      end
   end

   assign rx_code = rx_shift_reg[CODE_BITS-1:0];
   assign rx_is_addr = (rx_code[6:5] == ADDR_TAG);
   assign rx_node = rx_code[4:0];
   assign own_valid = (NODE_ADDRESS >= NODE_MIN) && (NODE_ADDRESS <= NODE_MAX);

   // Request framing and addressing
   always_ff @(posedge CLK) begin
      if (RST) begin
         link_state_reg <= LINK_ADDR;
         bcast_reg <= 1'b0;
         push_reg <= 1'b0;
         push_char_reg <= '0;
         bcc_reg <= '0;
         rx_error_reg <= 1'b0;
      end else if (CE) begin
         push_reg <= 1'b0;
         rx_error_reg <= rx_done_reg && !rx_good_reg;
         push_char_reg.code <= rx_code;
         push_char_reg.is_digit <= rx_code >= CH_DIGIT_0 &&
            rx_code <= CH_DIGIT_9;
         push_char_reg.is_ctrl <= rx_code == CH_STX || rx_code == CH_ETX ||
            rx_code == CH_EOT || rx_code == CH_ENQ || rx_code == CH_ACK ||
            rx_code == CH_NAK;
         if (rx_done_reg && rx_good_reg) begin
            if (rx_code == CH_EOT) begin
               link_state_reg <= LINK_ADDR;
               bcast_reg <= 1'b0;
            end else begin
               unique case (link_state_reg)
                  LINK_ADDR: begin
                     if (rx_is_addr && ((own_valid && rx_node == NODE_ADDRESS)
                         || rx_node == NODE_ANY || rx_node == NODE_BCAST)) begin
                        link_state_reg <= LINK_BODY;
                        bcast_reg <= (rx_node == NODE_BCAST);
                        push_reg <= 1'b1;
                     end else if (rx_is_addr) begin
                        link_state_reg <= LINK_SKIP;
                     end
                  end
                  LINK_SKIP, LINK_ANSWER: begin
                  end
                  LINK_BODY: begin
                     push_reg <= 1'b1;
                     if (rx_code == CH_STX) begin
                        bcc_reg <= '0;
                     end else begin
                        bcc_reg <= bcc_reg ^ rx_code;
                     end
                     if (rx_code == CH_ETX) begin
                        link_state_reg <= LINK_BCC;
                     end else if (rx_code == CH_ENQ) begin
                        link_state_reg <= bcast_reg ? LINK_SKIP : LINK_ANSWER;
                     end
                  end
                  LINK_BCC: begin
                     push_reg <= 1'b1;
                     link_state_reg <= bcast_reg ? LINK_SKIP : LINK_ANSWER;
                  end
               endcase
            end
         end else if (link_state_reg == LINK_ANSWER && tx_sent_reg &&
                      tx_last_reg) begin
            link_state_reg <= LINK_SKIP;
         end
      end
   end

   // Block check alarm, set beats clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         alarm_reg <= 1'b0;
      end else if (CE) begin
         if (rx_done_reg && rx_good_reg && link_state_reg == LINK_BCC &&
             rx_code != CH_EOT && rx_code != bcc_reg) begin
            alarm_reg <= 1'b1;
         end else if (ALARM_CLEAR) begin
            alarm_reg <= 1'b0;
         end
      end
   end

   // Decimal value after equals sign
   assign digit_val = VALUE_W'(push_char_reg.code - CH_DIGIT_0);
   assign acc_wide = (VALUE_W + 4)'(acc_reg) * (VALUE_W + 4)'(DECIMAL_BASE)
      + (VALUE_W + 4)'(digit_val);

   always_ff @(posedge CLK) begin
      if (RST) begin
         armed_reg <= 1'b0;
         acc_reg <= '0;
         value_reg <= '0;
         value_strobe_reg <= 1'b0;
         value_scale_reg <= 1'b1;
      end else if (CE) begin
         value_strobe_reg <= 1'b0;
         if (push_reg) begin
            if (push_char_reg.code == CH_EQUALS) begin
               armed_reg <= 1'b1;
               acc_reg <= '0;
            end else if (armed_reg && push_char_reg.is_digit) begin
               acc_reg <= (acc_wide > (VALUE_W + 4)'(VALUE_MAX)) ? VALUE_MAX :
                  acc_wide[VALUE_W-1:0];
            end else if (armed_reg) begin
               armed_reg <= 1'b0;
               value_reg <= acc_reg;
               value_strobe_reg <= 1'b1;
               value_scale_reg <= (acc_reg <= SPEED_FULL);
            end
         end
      end
   end

   char_fifo #(.WIDTH($bits(rx_char_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .in_valid(push_reg),
      .in_ready(fifo_in_ready),
      .in_data(push_char_reg),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   assign fifo_pop = fifo_out_valid && (!out_valid_reg || RX_READY);

   // Output stage and overrun report
   always_ff @(posedge CLK) begin
      if (RST) begin
         out_valid_reg <= 1'b0;
         out_char_reg <= '0;
         overrun_reg <= 1'b0;
      end else if (CE) begin
         overrun_reg <= push_reg && !fifo_in_ready;
         if (fifo_pop) begin
            out_valid_reg <= 1'b1;
            out_char_reg <= fifo_out_data;
         end else if (RX_READY) begin
            out_valid_reg <= 1'b0;
         end
      end
   end

   // Transmitter
   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= '0;
         tx_cnt_reg <= '0;
         tx_last_reg <= 1'b0;
         tx_sent_reg <= 1'b0;
         txd_reg <= 1'b1;
         tx_oe_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
      end else if (CE) begin
         tx_sent_reg <= 1'b0;
         tx_ready_reg <= tx_state_reg == TX_IDLE && !tx_take &&
            link_state_reg == LINK_ANSWER && !tx_sent_reg &&
            rx_state_reg == RX_IDLE && !rx_done_reg;
         unique case (tx_state_reg)
            TX_IDLE: begin
               if (tx_take) begin
                  tx_state_reg <= TX_START;
                  tx_shift_reg <= {^TX_CHAR.code, TX_CHAR.code};
                  tx_last_reg <= TX_CHAR.last;
                  txd_reg <= 1'b0;
                  tx_oe_reg <= 1'b1;
               end
            end
            TX_START: begin
               if (tx_zero) begin
                  tx_state_reg <= TX_DATA;
                  txd_reg <= tx_shift_reg[0];
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_cnt_reg <= '0;
               end
            end
            TX_DATA: begin
               if (tx_zero) begin
                  if (tx_cnt_reg == LAST_BIT) begin
                     tx_state_reg <= TX_STOP;
                     txd_reg <= 1'b1;
                  end else begin
                     txd_reg <= tx_shift_reg[0];
                     tx_shift_reg <= tx_shift_reg >> 1;
                     tx_cnt_reg <= tx_cnt_reg + 1'b1;
                  end
               end
            end
            TX_STOP: begin
               if (tx_zero) begin
                  tx_state_reg <= TX_IDLE;
                  tx_oe_reg <= 1'b0;
                  tx_sent_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   assign TXD = txd_reg;
   assign TX_OE = tx_oe_reg;
   assign TX_READY = tx_ready_reg;
   assign RX_CHAR = out_char_reg;
   assign RX_VALID = out_valid_reg;
   assign RX_ERROR = rx_error_reg;
   assign RX_OVERRUN = overrun_reg;
   assign BLOCK_CHECK_ALARM = alarm_reg;
   assign REQ_BROADCAST = bcast_reg;
   assign ANSWER_WINDOW = (link_state_reg == LINK_ANSWER);
   assign VALUE = value_reg;
   assign VALUE_STROBE = value_strobe_reg;
   assign VALUE_IN_SCALE = value_scale_reg;
endmodule : addressed_ascii_serial_slave
`default_nettype wire

// ---- sim/serial_master_model.sv ----
// Master model: sends requests on RXD, collects answers
`timescale 1ns/1ps
`default_nettype none
module serial_master_model #(
   parameter int BIT = 16
) (
   input wire logic clk, // System clock
   input wire logic txd, // Answer line
   output logic rxd // Request line
);
   logic [6:0] got_q[$];
   logic [8:0] f;
   int bad;
   initial rxd = 1'b1;
   // Start, code LSB first, even parity, stop, then idle high
   task automatic send(input logic [6:0] c, input logic bad_par,
      input logic bad_stop);
      logic [9:0] fr;
      fr = {~bad_stop, ^c ^ bad_par, c, 1'b0};
      @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         rxd = fr[i];
         repeat (BIT) @(negedge clk);
      end
      rxd = 1'b1;
      repeat (2 * BIT) @(negedge clk);
   endtask : send
   // Samples answer frames mid-bit
   initial forever begin
      @(negedge clk);
      if (txd === 1'b0) begin
         repeat (BIT / 2) @(negedge clk);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(negedge clk);
            f[i] = txd;
         end
         if (^f[7:0] === 1'b0 && f[8] === 1'b1) got_q.push_back(f[6:0]);
         else bad++;
      end
   end
endmodule : serial_master_model
`default_nettype wire

// ---- sim/addressed_ascii_serial_slave_checker.sv ----
// Port assertions of the serial slave
`timescale 1ns/1ps
`default_nettype none
module addressed_ascii_serial_slave_checker
   import serial_slave_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
   input wire logic CLK, // Clock
   input wire logic RST, // Reset
   input wire logic TXD, // Tx line
   input wire logic TX_OE, // Driver enable
   input wire rx_char_t RX_CHAR, // Rx char
   input wire logic RX_VALID, // Rx held
   input wire logic RX_READY, // Rx taken
   input wire logic TX_VALID, // Tx offered
   input wire logic TX_READY, // Tx accepted
   input wire logic RX_ERROR, // Rx fault
   input wire logic BLOCK_CHECK_ALARM, // Alarm
   input wire logic ALARM_CLEAR, // Alarm clear
   input wire logic REQ_BROADCAST, // Broadcast
   input wire logic ANSWER_WINDOW, // Answer allowed
   input wire logic [VALUE_W-1:0] VALUE, // Value
   input wire logic VALUE_STROBE, // Value new
   input wire logic VALUE_IN_SCALE // In scale
);
   int oe_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Cycles of the current frame
   always_ff @(posedge CLK) begin
      oe_cnt <= (RST || !TX_OE) ? 0 : oe_cnt + 1;
   end
   tx_idle_a: assert property (!TX_OE |-> TXD)
      else $error("TXD low, OE off");
   tx_gate_a: assert property (TX_READY |->
      ANSWER_WINDOW && !REQ_BROADCAST) else $error("ready outside window");
   tx_take_a: assert property (TX_VALID && TX_READY |=>
      !TXD && TX_OE && !TX_READY) else $error("no frame start");
   start_hold_a: assert property ($rose(TX_OE) |-> !TXD [*8])
      else $error("short start");
   frame_len_a: assert property ($fell(TX_OE) |->
      oe_cnt == 10 * BIT_CYCLES) else $error("frame length");
   rx_hold_a: assert property (RX_VALID && !RX_READY |=>
      RX_VALID && $stable(RX_CHAR)) else $error("char dropped");
   digit_flag_a: assert property (RX_VALID |-> RX_CHAR.is_digit ==
      (RX_CHAR.code inside {[CH_DIGIT_0:CH_DIGIT_9]}))
      else $error("digit flag");
   alarm_keep_a: assert property (BLOCK_CHECK_ALARM &&
      !ALARM_CLEAR |=> BLOCK_CHECK_ALARM) else $error("alarm lost");
   scale_flag_a: assert property (VALUE_STROBE |=>
      VALUE_IN_SCALE == (VALUE <= SPEED_FULL)) else $error("scale flag");
   cover property (RX_VALID && RX_READY);
   cover property ($fell(TX_OE));
   cover property ($rose(BLOCK_CHECK_ALARM));
   cover property (RX_ERROR);
endmodule : addressed_ascii_serial_slave_checker
bind addressed_ascii_serial_slave addressed_ascii_serial_slave_checker
   #(.BIT_CYCLES(BIT_CYCLES)) checker_i (.CLK(CLK), .RST(RST), .TXD(TXD),
   .TX_OE(TX_OE), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
   .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_ERROR(RX_ERROR),
   .BLOCK_CHECK_ALARM(BLOCK_CHECK_ALARM), .ALARM_CLEAR(ALARM_CLEAR),
   .REQ_BROADCAST(REQ_BROADCAST), .ANSWER_WINDOW(ANSWER_WINDOW),
   .VALUE(VALUE), .VALUE_STROBE(VALUE_STROBE), .VALUE_IN_SCALE(VALUE_IN_SCALE));
`default_nettype wire

// ---- sim/addressed_ascii_serial_slave_tb.sv ----
// Self-checking bench of the serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("mismatch %0t: %0h not %0h", $time, g, e); \
   end end
module addressed_ascii_serial_slave_tb;
   import serial_slave_pkg::*;
   typedef logic [6:0] cq_t[$];
   localparam int BITC = 16;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic RX_READY = 1'b1;
   logic TX_VALID = 1'b0;
   logic ALARM_CLEAR = 1'b0;
   logic [4:0] node = 5'h05;
   tx_char_t TX_CHAR = '0;
   rx_char_t RX_CHAR;
   logic [VALUE_W-1:0] VALUE;
   logic TXD, TX_OE, RXD, RX_VALID, TX_READY, RX_ERROR, RX_OVERRUN;
   logic BLOCK_CHECK_ALARM, REQ_BROADCAST, ANSWER_WINDOW;
   logic VALUE_STROBE, VALUE_IN_SCALE;
   int mismatches = 0;
   int total_checks = 0;
   int errs = 0;
   int ovrs = 0;
   logic [6:0] rxq[$];
   always #20 CLK = ~CLK;
   addressed_ascii_serial_slave #(.FIFO_DEPTH(8), .BIT_CYCLES(BITC))
      addressed_ascii_serial_slave_i (
      .CLK(CLK), .RST(RST), .CE(1'b1), .NODE_ADDRESS(node), .RXD(RXD),
      .TXD(TXD), .TX_OE(TX_OE), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .TX_CHAR(TX_CHAR), .TX_VALID(TX_VALID),
      .TX_READY(TX_READY), .RX_ERROR(RX_ERROR), .RX_OVERRUN(RX_OVERRUN),
      .BLOCK_CHECK_ALARM(BLOCK_CHECK_ALARM), .ALARM_CLEAR(ALARM_CLEAR),
      .REQ_BROADCAST(REQ_BROADCAST), .ANSWER_WINDOW(ANSWER_WINDOW),
      .VALUE(VALUE), .VALUE_STROBE(VALUE_STROBE),
      .VALUE_IN_SCALE(VALUE_IN_SCALE));
   serial_master_model #(.BIT(BITC)) serial_master_model_i (
      .clk(CLK), .txd(TXD), .rxd(RXD));
   always @(posedge CLK) begin
      if (RX_ERROR === 1'b1) errs++;
      if (RX_OVERRUN === 1'b1) ovrs++;
      if (RX_VALID === 1'b1 && RX_READY) rxq.push_back(RX_CHAR.code);
   end
   task automatic snd(input logic [6:0] c);
      serial_master_model_i.send(c, 1'b0, 1'b0);
   endtask : snd
   task automatic msg(input cq_t s);
      snd(CH_EOT);
      rxq.delete();
      foreach (s[i]) snd(s[i]);
   endtask : msg
   task automatic answer(input logic [6:0] c, input logic last);
      int n = 0;
      TX_CHAR = {last, c};
      TX_VALID = 1'b1;
      while (TX_READY !== 1'b1 && n < 500) begin
         @(negedge CLK);
         n++;
      end
      @(negedge CLK);
      TX_VALID = 1'b0;
      `CHK(n < 500, 1'b1)
      repeat (11 * BITC) @(negedge CLK);
   endtask : answer
   function automatic logic [6:0] bcc(input cq_t s);
      logic [6:0] x = '0;
      foreach (s[i]) x ^= s[i];
      return x;
   endfunction : bcc
   task automatic t_own;
      cq_t body, ans;
      body = '{CH_EQUALS, 7'h38, 7'h31, 7'h39, 7'h31, CH_ETX};
      ans = '{CH_STX, CH_ETX, CH_EOT, CH_ENQ, CH_ACK, CH_NAK};
      msg({7'h45, CH_STX, body, bcc(body)});
      `CHK(rxq.size(), 9)
      `CHK(rxq[0], 7'h45)
      `CHK(VALUE, SPEED_FULL)
      `CHK(VALUE_IN_SCALE, 1'b1)
      `CHK(BLOCK_CHECK_ALARM, 1'b0)
      `CHK(ANSWER_WINDOW, 1'b1)
      foreach (ans[i]) answer(ans[i], i == 5);
      foreach (ans[i]) `CHK(serial_master_model_i.got_q[i], ans[i])
      `CHK(serial_master_model_i.bad, 0)
      `CHK(ANSWER_WINDOW, 1'b0)
      $display("test own done");
   endtask : t_own
   task automatic t_select;
      msg('{7'h46, CH_ENQ});
      `CHK(rxq.size(), 0)
      `CHK(ANSWER_WINDOW, 1'b0)
      node = NODE_MAX;
      msg('{7'h40, CH_ENQ});
      `CHK(ANSWER_WINDOW, 1'b1)
      answer(CH_ACK, 1'b1);
      msg('{7'h5e, CH_ENQ});
      `CHK(ANSWER_WINDOW, 1'b1)
      answer(CH_ACK, 1'b1);
      node = 5'h05;
      $display("test select done");
   endtask : t_select
   task automatic t_bcast;
      logic seen = 1'b0;
      msg('{7'h5f, CH_STX, CH_ETX, CH_ETX});
      `CHK(rxq.size(), 4)
      `CHK(REQ_BROADCAST, 1'b1)
      `CHK(ANSWER_WINDOW, 1'b0)
      TX_CHAR = {1'b1, CH_ACK};
      TX_VALID = 1'b1;
      repeat (4 * BITC) begin
         @(negedge CLK);
         seen |= TX_READY;
      end
      TX_VALID = 1'b0;
      `CHK(seen, 1'b0)
      `CHK(TX_OE, 1'b0)
      $display("test bcast done");
   endtask : t_bcast
   task automatic t_bad;
      int e0 = errs;
      msg('{CH_EOT});
      serial_master_model_i.send(7'h45, 1'b1, 1'b0);
      serial_master_model_i.send(7'h45, 1'b0, 1'b1);
      snd(CH_ENQ);
      `CHK(errs - e0, 2)
      `CHK(rxq.size(), 0)
      `CHK(ANSWER_WINDOW, 1'b0)
      $display("test bad done");
   endtask : t_bad
   task automatic t_bcc;
      cq_t body;
      body = '{CH_EQUALS, 7'h38, 7'h31, 7'h39, 7'h32, CH_ETX};
      msg({7'h45, CH_STX, body, bcc(body) ^ 7'h01});
      `CHK(VALUE, 16'h2000)
      `CHK(VALUE_IN_SCALE, 1'b0)
      `CHK(BLOCK_CHECK_ALARM, 1'b1)
      `CHK(ANSWER_WINDOW, 1'b1)
      ALARM_CLEAR = 1'b1;
      @(negedge CLK);
      ALARM_CLEAR = 1'b0;
      @(negedge CLK);
      `CHK(BLOCK_CHECK_ALARM, 1'b0)
      answer(CH_NAK, 1'b1);
      $display("test bcc done");
   endtask : t_bcc
   task automatic t_ovr;
      int o0 = ovrs;
      RX_READY = 1'b0;
      msg('{7'h45});
      repeat (10) snd(7'h31);
      `CHK(ovrs > o0, 1'b1)
      RX_READY = 1'b1;
      repeat (20) @(negedge CLK);
      `CHK(rxq[0], 7'h45)
      `CHK(rxq.size(), 9)
      $display("test ovr done");
   endtask : t_ovr
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (6) @(negedge CLK);
      RST = 1'b0;
      t_own;
      t_select;
      t_bcast;
      t_bad;
      t_bcc;
      t_ovr;
      close_out;
   end
   initial begin
      repeat (40000) @(posedge CLK);
      mismatches++;
      $display("mismatch %0t: watchdog", $time);
      close_out;
   end
endmodule : addressed_ascii_serial_slave_tb
`default_nettype wire
